// file: hw/rst_seq.sv
// Reset initial-state sequencer with register port and interrupt
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
// Behaviour
// - Run-mode watchdog timeout: reset, timeout flag set
// - Sleep watchdog timeout: clear PC/SP, keep rest
// - Power-on clears timeout and power-down flags
// - Undervoltage reset keeps both flags
// - Sleep watchdog timeout sets both flags
// - Reset disables all interrupt sources
// - Reset clears watchdog, starts it, control 0x53
// - Reset switches all timers off
// - Reset makes ports inputs, data all ones
// - Reset points stack pointer at stack top
// - Per-type reset values; sleep keeps contents
// - Bad watchdog key resets after delay, flags
// - Undervoltage sets flag; only software clears
module rst_seq
  import rst_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    nrst,
  input  wire logic    uv_detect,
  input  wire logic    wdt_expire,
  input  wire mode_e   core_mode,
  input  wire logic    enter_halt,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic    wr_en,
  input  wire logic    rd_en,
  output logic [DW-1:0] rdata_r,
  output rst_cmd_s     rst_cmd_r,
  output flags_s       flags_r,
  output logic         wdt_run_r,
  output logic         wdt_clear_r,
  output logic [3:0]   stack_ptr_r,
  output logic [DW-1:0] int_enable_r,
  output logic [DW-1:0] timer_ctrl_r,
  output logic [DW-1:0] port_data_r,
  output logic [DW-1:0] port_dir_r,
  output logic         irq_r
);
  logic          uv_s0_r, uv_s1_r, uv_s2_r;
  logic          sleepish, uv_evt, wrun_evt, wslp_evt, key_evt, full;
  logic          key_ok_nxt, wr_hit_wdog;
  seq_e          seq_r, seq_nxt;
  logic [7:0]    cnt_r, cnt_nxt;
  logic [DW-1:0] wdog_r, wdog_nxt;
  logic          uvf_r, uvf_nxt, swf_r, swf_nxt;
  flags_s        flags_nxt;
  rst_cmd_s      cmd_nxt;
  logic [DW-1:0] inten_nxt, timer_nxt, pdata_nxt, pdir_nxt, rdata_nxt;
  logic [3:0]    sp_nxt;
  logic [IRQ_N-1:0] istat_r, istat_nxt, imask_r, imask_nxt, iev;
  logic          irq_nxt, wrun_nxt, wclr_nxt;

  // Detector level is analog-side, so it is synchronised first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uv_s0_r <= 1'b0;
      uv_s1_r <= 1'b0;
      uv_s2_r <= 1'b0;
    end else begin
      uv_s0_r <= uv_detect;
      uv_s1_r <= uv_s0_r;
      uv_s2_r <= uv_s1_r;
    end
  end

  // Event decode; undervoltage watch is off in idle and sleep
  always_comb begin
    sleepish = (core_mode == MODE_IDLE) || (core_mode == MODE_SLEEP);
    uv_evt   = uv_s1_r && !uv_s2_r && !sleepish;
    wrun_evt = wdt_expire && !sleepish;
    wslp_evt = wdt_expire && sleepish;
    key_evt  = (seq_r == SEQ_KEY_WAIT) && (cnt_r == SRESET_LAST);
    full     = uv_evt || wrun_evt || key_evt;
    wr_hit_wdog = wr_en && (addr == REG_WDOG);
    iev      = {key_evt, wslp_evt, wrun_evt, uv_evt};
  end

  // Bad-key delay sequencer
  always_comb begin
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    case (seq_r)
      SEQ_RUN: begin
        if (!full && !key_ok_nxt) begin
          seq_nxt = SEQ_KEY_WAIT;
          cnt_nxt = CNT_ZERO;
        end
      end
      SEQ_KEY_WAIT: begin
        // A later key write cannot cancel a pending reset
        if (full) begin
          seq_nxt = SEQ_RUN;
          cnt_nxt = CNT_ZERO;
        end else begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
      default: begin
        seq_nxt = SEQ_RUN;
        cnt_nxt = CNT_ZERO;
      end
    endcase
  end

  // Register file and per-type reset loading
  always_comb begin
    wdog_nxt  = wdog_r;
    inten_nxt = int_enable_r;
    timer_nxt = timer_ctrl_r;
    pdata_nxt = port_data_r;
    pdir_nxt  = port_dir_r;
    imask_nxt = imask_r;
    uvf_nxt   = uvf_r;
    swf_nxt   = swf_r;
    if (wr_en) begin
      case (addr)
        REG_WDOG:  wdog_nxt  = wdata;
        REG_INTEN: inten_nxt = wdata;
        REG_TIMER: timer_nxt = wdata;
        REG_PDATA: pdata_nxt = wdata;
        REG_PDIR:  pdir_nxt  = wdata;
        REG_IMASK: imask_nxt = wdata[IRQ_N-1:0];
        REG_RFLAGS: begin
          uvf_nxt = wdata[UVF_BIT];
          swf_nxt = wdata[SWF_BIT];
        end
        default: ;
      endcase
    end
    // Full resets override a write to the five registers they reload in the same cycle; IMASK and RFLAGS writes still land
    if (full) begin
      wdog_nxt  = WDOG_RST;
      inten_nxt = ZERO8;
      timer_nxt = ZERO8;
      pdata_nxt = PORT_RST;
      pdir_nxt  = PORT_RST;
    end
    // Hardware set wins over the software clear
    if (uv_evt)
      uvf_nxt = 1'b1;
    if (key_evt)
      swf_nxt = 1'b1;
    key_ok_nxt = (wdog_nxt[7:KEY_LSB] == KEY_A) ||
                 (wdog_nxt[7:KEY_LSB] == KEY_B);
  end

  // Status flags and reset commands per reset type
  always_comb begin
    flags_nxt = flags_r;
    if (enter_halt) begin
      flags_nxt.power_down_flag  = 1'b1;
      flags_nxt.wdt_timeout_flag = 1'b0;
    end
    // Undervoltage and key resets leave both flags
    if (wrun_evt)
      flags_nxt.wdt_timeout_flag = 1'b1;
    if (wslp_evt) begin
      flags_nxt.wdt_timeout_flag = 1'b1;
      flags_nxt.power_down_flag  = 1'b1;
    end
    cmd_nxt.full  = full;
    cmd_nxt.pc_sp = full || wslp_evt;
    sp_nxt   = cmd_nxt.pc_sp ? STACK_TOP : stack_ptr_r;
    wclr_nxt = full || wslp_evt;
    wrun_nxt = key_ok_nxt;
  end

  // Interrupt status clears on read; new events win
  always_comb begin
    istat_nxt = istat_r;
    if (rd_en && addr == REG_ISTAT)
      istat_nxt = '0;
    istat_nxt = istat_nxt | iev;
    irq_nxt   = |(istat_nxt & imask_nxt);
    rdata_nxt = ZERO8;
    if (rd_en) begin
      case (addr)
        REG_WDOG:   rdata_nxt = wdog_r;
        REG_RFLAGS: begin
          rdata_nxt[UVF_BIT] = uvf_r;
          rdata_nxt[SWF_BIT] = swf_r;
        end
        REG_STATUS: begin
          rdata_nxt[TMO_BIT]   = flags_r.wdt_timeout_flag;
          rdata_nxt[PWRDN_BIT] = flags_r.power_down_flag;
        end
        REG_INTEN:  rdata_nxt = int_enable_r;
        REG_TIMER:  rdata_nxt = timer_ctrl_r;
        REG_PDATA:  rdata_nxt = port_data_r;
        REG_PDIR:   rdata_nxt = port_dir_r;
        REG_ISTAT:  rdata_nxt[IRQ_N-1:0] = istat_r;
        REG_IMASK:  rdata_nxt[IRQ_N-1:0] = imask_r;
        default:    rdata_nxt = ZERO8;
      endcase
    end
  end

  // Power-on state; core is held in full reset while nrst is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_r        <= SEQ_RUN;
      cnt_r        <= CNT_ZERO;
      wdog_r       <= WDOG_RST;
      int_enable_r <= ZERO8;
      timer_ctrl_r <= ZERO8;
      port_data_r  <= PORT_RST;
      port_dir_r   <= PORT_RST;
      imask_r      <= '0;
      istat_r      <= '0;
      uvf_r        <= 1'b0;
      swf_r        <= 1'b0;
      flags_r      <= '0;
      rst_cmd_r    <= '1;
      stack_ptr_r  <= STACK_TOP;
      wdt_clear_r  <= 1'b1;
      wdt_run_r    <= 1'b1;
      irq_r        <= 1'b0;
      rdata_r      <= ZERO8;
    end else begin
      seq_r        <= seq_nxt;
      cnt_r        <= cnt_nxt;
      wdog_r       <= wdog_nxt;
      int_enable_r <= inten_nxt;
      timer_ctrl_r <= timer_nxt;
      port_data_r  <= pdata_nxt;
      port_dir_r   <= pdir_nxt;
      imask_r      <= imask_nxt;
      istat_r      <= istat_nxt;
      uvf_r        <= uvf_nxt;
      swf_r        <= swf_nxt;
      flags_r      <= flags_nxt;
      rst_cmd_r    <= cmd_nxt;
      stack_ptr_r  <= sp_nxt;
      wdt_clear_r  <= wclr_nxt;
      wdt_run_r    <= wrun_nxt;
      irq_r        <= irq_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  localparam int AST_KEY_MAX = SRESET_CYC_I + 1;

  sequence bad_key_write;
    wr_hit_wdog && !full && (seq_r == SEQ_RUN) &&
    (wdata[7:KEY_LSB] != KEY_A) && (wdata[7:KEY_LSB] != KEY_B);
  endsequence

  sequence key_reset_done;
    rst_cmd_r.full && swf_r;
  endsequence

  AST_WDT_RUN_TO: assert property (
    @(posedge clk) disable iff (!nrst)
    wrun_evt |=> flags_r.wdt_timeout_flag && rst_cmd_r.full)
    else $error("run-mode timeout did not reset with flag");

  AST_WDT_RUN_PWRDN: assert property (
    @(posedge clk) disable iff (!nrst)
    wrun_evt && !enter_halt |=>
      flags_r.power_down_flag == $past(flags_r.power_down_flag))
    else $error("run-mode timeout changed power-down flag");

  AST_WDT_SLEEP: assert property (
    @(posedge clk) disable iff (!nrst)
    wslp_evt |=> flags_r == 2'b11 && rst_cmd_r.pc_sp && !rst_cmd_r.full
      && $stable(int_enable_r) && $stable(port_dir_r))
    else $error("sleep timeout handled wrongly");

  AST_UV_KEEP: assert property (
    @(posedge clk) disable iff (!nrst)
    uv_evt && !wdt_expire && !enter_halt |=>
      $stable(flags_r) && uvf_r && rst_cmd_r.full)
    else $error("undervoltage reset flags wrong");

  AST_INIT_OFF: assert property (
    @(posedge clk) disable iff (!nrst)
    rst_cmd_r.full |-> int_enable_r == ZERO8 && timer_ctrl_r == ZERO8)
    else $error("interrupts or timers on after reset");

  AST_PORT_IN: assert property (
    @(posedge clk) disable iff (!nrst)
    rst_cmd_r.full |-> port_dir_r == PORT_RST && port_data_r == PORT_RST)
    else $error("ports not inputs after reset");

  AST_WDOG_INIT: assert property (
    @(posedge clk) disable iff (!nrst)
    rst_cmd_r.full |-> wdt_clear_r && wdt_run_r && wdog_r == WDOG_RST
      && rst_cmd_r.pc_sp && stack_ptr_r == STACK_TOP)
    else $error("watchdog or stack not initialised");

  AST_KEY_RESET: assert property (
    @(posedge clk) disable iff (!nrst)
    bad_key_write |=> !wdt_run_r ##[1:AST_KEY_MAX] key_reset_done)
    else $error("bad key did not reset in time");

  AST_UVF_SW_CLEAR: assert property (
    @(posedge clk) disable iff (!nrst)
    $fell(uvf_r) |-> $past(wr_en && addr == REG_RFLAGS))
    else $error("undervoltage flag cleared without write");

  // Bad-key reset leaves the status flags alone, like undervoltage
  AST_SWF_SET: assert property (
    @(posedge clk) disable iff (!nrst)
    key_evt && !wdt_expire && !enter_halt |=>
      swf_r && rst_cmd_r.full && $stable(flags_r))
    else $error("bad-key reset did not set its flag");

  // Guarded against writes so only the timeout itself is judged
  AST_SLEEP_KEEP: assert property (
    @(posedge clk) disable iff (!nrst)
    wslp_evt && !wr_en && !full |=>
      stack_ptr_r == STACK_TOP && wdt_clear_r && $stable(wdog_r)
      && $stable(port_data_r) && $stable(timer_ctrl_r))
    else $error("sleep timeout changed kept registers");

  AST_RUN_IRQ: assert property (
    @(posedge clk) disable iff (!nrst)
    wrun_evt |=> istat_r[1])
    else $error("run-mode timeout not recorded");

endmodule // rst_seq

// file: pkg/rst_pkg.sv
// Constants and types for the reset initial-state sequencer
package rst_pkg;
  localparam int AW = 8;
  localparam int DW = 8;
  // Register offsets
  localparam logic [AW-1:0] REG_WDOG   = 8'h00;
  localparam logic [AW-1:0] REG_RFLAGS = 8'h04;
  localparam logic [AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AW-1:0] REG_INTEN  = 8'h0c;
  localparam logic [AW-1:0] REG_TIMER  = 8'h10;
  localparam logic [AW-1:0] REG_PDATA  = 8'h14;
  localparam logic [AW-1:0] REG_PDIR   = 8'h18;
  localparam logic [AW-1:0] REG_ISTAT  = 8'h1c;
  localparam logic [AW-1:0] REG_IMASK  = 8'h20;
  // Reset values and fields
  localparam logic [DW-1:0] WDOG_RST = 8'h53;
  localparam logic [DW-1:0] PORT_RST = 8'hff;
  localparam logic [DW-1:0] ZERO8    = 8'h00;
  localparam logic [4:0]    KEY_A    = 5'h0a;
  localparam logic [4:0]    KEY_B    = 5'h15;
  localparam int KEY_LSB = 3;
  localparam int TMO_BIT   = 5;
  localparam int PWRDN_BIT = 4;
  localparam int UVF_BIT = 2;
  localparam int SWF_BIT = 0;
  localparam int IRQ_N   = 4;
  localparam logic [3:0] STACK_TOP = 4'h0;
  // Delay before a bad watchdog key resets the device
  localparam int CLK_PERIOD_NS = 4;
  localparam int SRESET_NS     = 1000;
  localparam int SRESET_CYC_I  =
    (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SRESET_LAST = 8'(SRESET_CYC_I - 1);
  localparam logic [7:0] CNT_ZERO    = 8'h00;
  localparam logic [7:0] CNT_ONE     = 8'h01;

  typedef enum logic [1:0] {
    MODE_FAST  = 2'b00,
    MODE_SLOW  = 2'b01,
    MODE_IDLE  = 2'b10,
    MODE_SLEEP = 2'b11
  } mode_e;

  typedef enum logic {
    SEQ_RUN      = 1'b0,
    SEQ_KEY_WAIT = 1'b1
  } seq_e;

  // Reset commands to the core: full re-init, or PC/SP clear only
  typedef struct packed {
    logic full;
    logic pc_sp;
  } rst_cmd_s;

  // Status register reset flags
  typedef struct packed {
    logic wdt_timeout_flag;
    logic power_down_flag;
  } flags_s;
endpackage

// file: tb/mcu_reset_initial_state_tb.sv
// Self-checking bench for the reset initial-state sequencer
`timescale 1ns/100ps
module mcu_reset_initial_state_tb
  import rst_pkg::*;
;
  logic            clk, nrst, uv_detect, wdt_expire, enter_halt;
  logic            wr_en, rd_en;
  mode_e           core_mode;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wdata, rdata_r, int_enable_r, timer_ctrl_r;
  logic [DW-1:0]   port_data_r, port_dir_r;
  rst_cmd_s        rst_cmd_r;
  flags_s          flags_r;
  logic            wdt_run_r, wdt_clear_r, irq_r;
  logic [3:0]      stack_ptr_r;
  logic [7:0]      m [0:8];
  logic [7:0]      v;
  logic            tmo, pwrdn;
  int              mismatches, num_checks, n, seed;

  rst_seq uut (.clk(clk), .nrst(nrst), .uv_detect(uv_detect),
    .wdt_expire(wdt_expire), .core_mode(core_mode),
    .enter_halt(enter_halt), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_r(rdata_r), .rst_cmd_r(rst_cmd_r),
    .flags_r(flags_r), .wdt_run_r(wdt_run_r), .wdt_clear_r(wdt_clear_r),
    .stack_ptr_r(stack_ptr_r), .int_enable_r(int_enable_r),
    .timer_ctrl_r(timer_ctrl_r), .port_data_r(port_data_r),
    .port_dir_r(port_dir_r), .irq_r(irq_r));

  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Model update mirrors only the writable places; status is read-only
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    if (a == REG_RFLAGS) m[1] = d & 8'h05;
    else if (a == REG_IMASK) m[8] = d & 8'h0f; // Four sources only
    else if (a != REG_STATUS && a != REG_ISTAT && a <= REG_IMASK &&
             a[1:0] == 2'b00) m[a[7:2]] = d;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1; addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata_r;
  endtask

  task full_rst;
    m[0] = WDOG_RST; m[3] = ZERO8; m[4] = ZERO8;
    m[5] = PORT_RST; m[6] = PORT_RST;
  endtask

  task set_flags(input logic t, input logic p);
    tmo = t; pwrdn = p;
    m[2] = {2'b00, t, p, 4'h0};
  endtask

  // Read every place except the clear-on-read status and compare pins
  task cmp_all;
    for (int i = 0; i < 9; i++) begin
      if (i != 7) begin
        rd(8'(i * 4), v);
        chk(v, m[i]);
      end
    end
    chk(int_enable_r, m[3]);
    chk(timer_ctrl_r, m[4]);
    chk(port_data_r, m[5]);
    chk(port_dir_r, m[6]);
    chk({6'h0, flags_r}, {6'h0, tmo, pwrdn});
  endtask

  task rnd_regs;
    for (int i = 3; i < 7; i++) wr(8'(i * 4), 8'($random(seed)));
  endtask

  // One-cycle watchdog overflow in the given core mode
  task expire(input mode_e md);
    @(posedge clk);
    core_mode <= md; wdt_expire <= 1'b1;
    @(posedge clk);
    wdt_expire <= 1'b0;
    #1;
  endtask

  task istat_clr(input logic [7:0] exp);
    rd(REG_ISTAT, v);
    chk(v, exp);
    @(posedge clk);
    #1 chk({7'h0, irq_r}, 8'h00);
  endtask

  // Hang guard, far beyond the roughly 410 cycles the tests need
  initial begin
    #40000;
    mismatches++;
    give_verdict;
  end

  initial begin
    seed = 61941;
    mismatches = 0; num_checks = 0;
    nrst = 1'b0; uv_detect = 1'b0; wdt_expire = 1'b0; enter_halt = 1'b0;
    wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wdata = 8'h00;
    core_mode = MODE_FAST;
    full_rst;
    m[1] = ZERO8; m[7] = ZERO8; m[8] = ZERO8;
    set_flags(1'b0, 1'b0);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    #1 chk({4'h0, stack_ptr_r}, {4'h0, STACK_TOP});
    chk({7'h0, wdt_run_r}, 8'h01);
    cmp_all;
    // Random contents, unmapped place, then a run-mode overflow
    wr(REG_IMASK, 8'hff);
    rnd_regs;
    wr(8'h24, 8'h5a);
    rd(8'h24, v);
    chk(v, ZERO8);
    @(posedge clk);
    enter_halt <= 1'b1;
    @(posedge clk);
    enter_halt <= 1'b0;
    set_flags(1'b0, 1'b1);
    expire(MODE_FAST);
    chk({6'h0, rst_cmd_r}, 8'h03);
    chk({7'h0, wdt_clear_r}, 8'h01);
    full_rst;
    set_flags(1'b1, pwrdn);
    @(posedge clk);
    #1 chk({7'h0, irq_r}, 8'h01);
    wr(REG_IMASK, 8'h00);
    @(posedge clk);
    #1 chk({7'h0, irq_r}, 8'h00);
    wr(REG_IMASK, 8'hff);
    cmp_all;
    istat_clr(8'h02);
    // Halt clears the timeout flag, sleep overflow keeps the rest
    rnd_regs;
    @(posedge clk);
    enter_halt <= 1'b1;
    @(posedge clk);
    enter_halt <= 1'b0;
    set_flags(1'b0, 1'b1);
    expire(MODE_SLEEP);
    chk({6'h0, rst_cmd_r}, 8'h01);
    set_flags(1'b1, 1'b1);
    @(posedge clk);
    #1 chk({4'h0, stack_ptr_r}, {4'h0, STACK_TOP});
    cmp_all;
    istat_clr(8'h04);
    // Undervoltage is ignored in sleep, acted on in slow mode
    @(posedge clk);
    uv_detect <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1 if (rst_cmd_r.full === 1'b1) n++;
    end
    chk(8'(n), 8'h00);
    uv_detect <= 1'b0;
    repeat (4) @(posedge clk);
    core_mode <= MODE_SLOW;
    uv_detect <= 1'b1;
    n = 0;
    while (rst_cmd_r.full !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h0, rst_cmd_r.full}, 8'h01);
    full_rst;
    m[1] = m[1] | 8'h04;
    uv_detect <= 1'b0;
    cmp_all;
    istat_clr(8'h01);
    wr(REG_RFLAGS, 8'h00);
    rd(REG_RFLAGS, v);
    chk(v, 8'h00);
    // Bad watchdog key: stop, wait the fixed delay, then full reset
    wr(REG_WDOG, 8'h00);
    #1 chk({7'h0, wdt_run_r}, 8'h00);
    n = 0;
    while (rst_cmd_r.full !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk(8'(n), 8'(SRESET_CYC_I));
    full_rst;
    m[1] = m[1] | 8'h01;
    @(posedge clk);
    #1 chk({7'h0, wdt_run_r}, 8'h01);
    cmp_all;
    istat_clr(8'h08);
    give_verdict;
  end
endmodule // mcu_reset_initial_state_tb
